// ==== logic/umst_pkg.sv ====
// constants and types for the master spi transfer block
// assumes a single 100 MHz clock domain; no bus, control bits are ports
//
// Operation
// - transfers only while transmitter is enabled
// - transmitter enable hands output pin to shifter
// - receiver optional, transmit works without it
// - receiver enable hands input pin to sampler
// - transfer clock pin clocks every transfer
// - data write starts transfer and reception
// - buffer moves to shifter when shifter free
// - overflow drops newest byte, keeps oldest
// - frame, overrun, parity flags read zero
// - status flags behave as normal usart
// - disabling acts as in normal usart
// - receive flag tracks unread data, flush on disable
// - transmit complete sets when idle, write-one clears
// - data empty flag high when buffer free
// - transmitter disable waits until nothing pending
package umst_pkg;
   // ==================================================================
   // sizes and reset values
   localparam int FRAME_BITS = 8;
   localparam int RX_DEPTH = 2;
   localparam logic [11:0] BAUD_RESET = 12'h000;
   localparam logic XCK_IDLE_LOW = 1'b0;
   localparam logic SDO_IDLE = 1'b1;
   // shifter states
   typedef enum logic [1:0] {
      UMST_IDLE = 2'b00,
      UMST_LEAD = 2'b01,
      UMST_TRAIL = 2'b10
   } umst_state_t;
endpackage

// ==== logic/umst_rx_buffer.sv ====
// two-deep receive buffer that keeps the oldest bytes
// assumes push and pop are single-cycle pulses on mclk
`timescale 1ns/1ps
module umst_rx_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic flush,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   output logic [WIDTH-1:0] head_data,
   output logic not_empty
);
   import umst_pkg::*;
   // ==================================================================
   // storage
   // refuse depths the shuffle logic cannot serve
   if (DEPTH != 2) begin : g_bad_depth
      $error("umst_rx_buffer: depth must be 2");
   end
   logic [WIDTH-1:0] mem_reg [DEPTH]; // slot 0 is the head
   logic [1:0] count_reg; // bytes held
   logic do_pop; // a pop with data present
   assign do_pop = pop && (count_reg != 2'h0);
   assign not_empty = (count_reg != 2'h0);
   assign head_data = mem_reg[0];
   // count and shuffle
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= 2'h0;
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
      end else if (flush) begin
         count_reg <= 2'h0;
      end else begin
         if (do_pop) begin
            mem_reg[0] <= mem_reg[1];
         end
         if (push && (count_reg != 2'h2 || do_pop)) begin
            if (do_pop) begin
               if (count_reg == 2'h1) mem_reg[0] <= push_data;
               else mem_reg[1] <= push_data;
            end else if (count_reg == 2'h0) begin
               mem_reg[0] <= push_data;
            end else begin
               mem_reg[1] <= push_data;
            end
         end
         if (do_pop && !push) count_reg <= count_reg - 2'h1;
         else if (push && !do_pop && count_reg != 2'h2)
            count_reg <= count_reg + 2'h1;
      end
   end
endmodule

// ==== logic/umst_spi_master.sv ====
// master spi transfer engine: transmit buffer, shifter, clock, receive
// assumes software strobes are one-cycle pulses on mclk
`timescale 1ns/1ps
module umst_spi_master #(
   parameter int FRAME = umst_pkg::FRAME_BITS
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic tx_enable, // transmitter enable bit
   input wire logic rx_enable, // receiver enable bit
   input wire logic data_order_lsb, // 1 sends lsb first
   input wire logic clock_phase, // 1 samples on trailing edge
   input wire logic clock_polarity, // 1 idles clock high
   input wire logic [11:0] baud_div, // half period = baud_div+1 cycles
   input wire logic data_write, // write strobe to data location
   input wire logic [7:0] data_wdata,
   input wire logic data_read, // read strobe of data location
   output logic [7:0] data_rdata,
   input wire logic tx_complete_clear, // write one to transmit complete
   input wire logic tx_complete_ack, // interrupt executed
   output logic receive_complete_flag,
   output logic transmit_complete_flag,
   output logic data_empty_flag,
   output logic frame_error_flag,
   output logic overrun_flag,
   output logic parity_error_flag,
   output logic tx_active, // transmitter owns the output pin
   output logic rx_active, // receiver owns the input pin
   output logic serial_output_pin,
   output logic serial_output_pin_oe_n,
   input wire logic serial_input_pin,
   output logic transfer_clock_pin
);
   import umst_pkg::*;
   // ==================================================================
   // checks and synchronised input
   // refuse frame lengths the bit counter cannot serve
   if (FRAME != 8) begin : g_bad_frame
      $error("umst_spi_master: frame must be 8 bits");
   end
   logic sdi_meta_reg, sdi_sync_reg; // two-flop input sync
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         sdi_meta_reg <= 1'b0;
         sdi_sync_reg <= 1'b0;
      end else begin
         sdi_meta_reg <= serial_input_pin;
         sdi_sync_reg <= sdi_meta_reg;
      end
   end
   // ==================================================================
   // enables
   logic tx_on_reg; // transmitter really enabled
   logic buf_full_reg; // transmit buffer holds a byte
   logic [7:0] buf_reg;
   umst_state_t state_reg;
   logic shifting; // shifter busy
   assign shifting = (state_reg != UMST_IDLE);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         tx_on_reg <= 1'b0;
      end else if (tx_enable) begin
         tx_on_reg <= 1'b1;
      end else if (!buf_full_reg && !shifting && !data_write) begin
         // a write landing on the last cycle keeps the transmitter on,
         // otherwise that byte would be stranded in the buffer
         // same disable behaviour
         tx_on_reg <= 1'b0;
      end
   end
   assign tx_active = tx_on_reg;
   assign serial_output_pin_oe_n = !tx_on_reg;
   assign rx_active = rx_enable;
   assign frame_error_flag = 1'b0;
   assign overrun_flag = 1'b0;
   assign parity_error_flag = 1'b0;
   // ==================================================================
   // transmit buffer
   logic load; // buffer to shifter move
   assign load = buf_full_reg && !shifting && tx_on_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         buf_full_reg <= 1'b0;
         buf_reg <= 8'h00;
      end else if (data_write && tx_on_reg && !buf_full_reg) begin
         buf_full_reg <= 1'b1;
         buf_reg <= data_wdata;
      end else if (load) begin
         buf_full_reg <= 1'b0;
      end
   end
   assign data_empty_flag = !buf_full_reg;
   // ==================================================================
   // baud divider: one-cycle enable per half bit
   logic [11:0] div_reg;
   logic half_tick;
   assign half_tick = shifting && (div_reg == 12'h000);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         div_reg <= BAUD_RESET;
      end else if (!shifting || half_tick) begin
         div_reg <= baud_div;
      end else begin
         div_reg <= div_reg - 12'h001;
      end
   end
   // ==================================================================
   // shifter
   logic [7:0] tx_sh_reg, rx_sh_reg;
   logic [2:0] bit_reg; // bits done in frame
   logic sck_reg; // clock before polarity
   logic sdo_reg;
   logic frame_done; // last trailing edge
   logic tx_out_bit, rx_in_bit;
   logic [7:0] rx_frame;
   assign tx_out_bit = data_order_lsb ? tx_sh_reg[0] : tx_sh_reg[7];
   assign frame_done = half_tick && state_reg == UMST_TRAIL &&
      bit_reg == 3'h7;
   assign rx_in_bit = sdi_sync_reg;
   // byte as received, with the bit sampled on the last edge
   assign rx_frame = data_order_lsb ? {rx_in_bit, rx_sh_reg[7:1]} :
      {rx_sh_reg[6:0], rx_in_bit};
   // state, clock and data
   // eight bits each way
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= UMST_IDLE;
         tx_sh_reg <= 8'h00;
         rx_sh_reg <= 8'h00;
         bit_reg <= 3'h0;
         sck_reg <= XCK_IDLE_LOW;
         sdo_reg <= SDO_IDLE;
      end else begin
         unique case (state_reg)
            UMST_IDLE: begin
               sck_reg <= XCK_IDLE_LOW;
               if (load) begin
                  tx_sh_reg <= buf_reg;
                  bit_reg <= 3'h0;
                  state_reg <= UMST_LEAD;
                  // phase 0 sets up the first bit before leading edge
                  if (!clock_phase) begin
                     sdo_reg <= data_order_lsb ? buf_reg[0] : buf_reg[7];
                  end
               end
            end
            UMST_LEAD: begin
               if (half_tick) begin
                  sck_reg <= 1'b1;
                  state_reg <= UMST_TRAIL;
                  if (clock_phase) begin
                     sdo_reg <= tx_out_bit;
                  end else begin
                     rx_sh_reg <= rx_frame;
                  end
                  // shift after the bit is on the line
                  tx_sh_reg <= data_order_lsb ? {1'b0, tx_sh_reg[7:1]} :
                     {tx_sh_reg[6:0], 1'b0};
               end
            end
            UMST_TRAIL: begin
               if (half_tick) begin
                  sck_reg <= 1'b0;
                  bit_reg <= bit_reg + 3'h1;
                  if (clock_phase) begin
                     rx_sh_reg <= rx_frame;
                  end else if (bit_reg != 3'h7) begin
                     sdo_reg <= tx_out_bit;
                  end
                  state_reg <= (bit_reg == 3'h7) ? UMST_IDLE : UMST_LEAD;
               end
            end
            default: state_reg <= UMST_IDLE;
         endcase
      end
   end
   assign transfer_clock_pin = sck_reg ^ clock_polarity;
   assign serial_output_pin = tx_on_reg ? sdo_reg : SDO_IDLE;
   // ==================================================================
   // received byte capture at frame end
   logic rx_push_reg; // one-cycle push after the frame
   logic [7:0] rx_byte_reg;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rx_push_reg <= 1'b0;
         rx_byte_reg <= 8'h00;
      end else begin
         rx_push_reg <= frame_done && rx_enable;
         if (frame_done) begin
            // phase 0 sampled the last bit on the leading edge already
            rx_byte_reg <= clock_phase ? rx_frame : rx_sh_reg;
         end
      end
   end
   logic rx_has;
   logic [7:0] rx_head;
   umst_rx_buffer #(
      .WIDTH(8),
      .DEPTH(RX_DEPTH)
   ) u_rx_buffer (
      .mclk(mclk),
      .reset_n(reset_n),
      .flush(!rx_enable),
      .push(rx_push_reg),
      .push_data(rx_byte_reg),
      .pop(data_read),
      .head_data(rx_head),
      .not_empty(rx_has)
   );
   assign receive_complete_flag = rx_has;
   // head byte returned on each read
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         data_rdata <= 8'h00;
      end else begin
         data_rdata <= rx_head;
      end
   end
   // ==================================================================
   // transmit complete, set wins over clear
   logic txc_reg;
   // set at frame end with buffer empty, clear by write or ack
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         txc_reg <= 1'b0;
      end else if (frame_done && !buf_full_reg) begin
         txc_reg <= 1'b1;
      end else if (tx_complete_clear || tx_complete_ack) begin
         txc_reg <= 1'b0;
      end
   end
   assign transmit_complete_flag = txc_reg;
endmodule

// ==== verif/umst_spi_master_sva.sv ====
// checker for the master spi transfer block
// assumes one mclk domain; sees only the top module ports
`timescale 1ns/1ps
module umst_spi_master_sva (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic rx_enable,
   input wire logic clock_polarity,
   input wire logic data_write,
   input wire logic receive_complete_flag,
   input wire logic transmit_complete_flag,
   input wire logic data_empty_flag,
   input wire logic frame_error_flag,
   input wire logic overrun_flag,
   input wire logic parity_error_flag,
   input wire logic tx_active,
   input wire logic rx_active,
   input wire logic serial_output_pin,
   input wire logic serial_output_pin_oe_n,
   input wire logic transfer_clock_pin
);
   // ==========================================================
   // properties
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);
   property p_err_zero;
      !(frame_error_flag | overrun_flag | parity_error_flag);
   endproperty
   a_err_zero: assert property (p_err_zero)
      else $error("receive error flag set");
   property p_pin_own;
      serial_output_pin_oe_n == !tx_active;
   endproperty
   a_pin_own: assert property (p_pin_own)
      else $error("output enable disagrees with transmitter");
   property p_sdo_idle;
      !tx_active |-> serial_output_pin;
   endproperty
   a_sdo_idle: assert property (p_sdo_idle)
      else $error("output pin not idle high");
   property p_clk_quiet;
      !tx_active |-> transfer_clock_pin == clock_polarity;
   endproperty
   a_clk_quiet: assert property (p_clk_quiet)
      else $error("clock moved while transmitter off");
   property p_rx_own;
      rx_active == rx_enable;
   endproperty
   a_rx_own: assert property (p_rx_own)
      else $error("receiver ownership wrong");
   property p_write_take;
      data_write && tx_active && data_empty_flag |=> !data_empty_flag;
   endproperty
   a_write_take: assert property (p_write_take)
      else $error("write not taken");
   property p_flush;
      !rx_enable |=> !receive_complete_flag;
   endproperty
   a_flush: assert property (p_flush)
      else $error("receive buffer not flushed");
   property p_tc_rise;
      // buffer state at the frame end, a write may land on that edge
      $rose(transmit_complete_flag) |-> $past(data_empty_flag);
   endproperty
   a_tc_rise: assert property (p_tc_rise)
      else $error("transmit complete with byte pending");
   property p_tx_off;
      $fell(tx_active) |-> data_empty_flag
         && transfer_clock_pin == clock_polarity;
   endproperty
   a_tx_off: assert property (p_tx_off)
      else $error("transmitter stopped with data pending");
   c_tc: cover property ($rose(transmit_complete_flag));
   c_flush: cover property ($fell(receive_complete_flag) && !rx_enable);
   c_tx_off: cover property ($fell(tx_active));
endmodule

// ==== verif/umst_slave_model.sv ====
// spi slave model on the far side of the transfer block
// assumes mode bits change only while the link is idle
`timescale 1ns/1ps
module umst_slave_model (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic lsb_first,
   output logic miso,
   output logic [7:0] got,
   output int frames
);
   // ==========================================================
   // shifter
   logic [7:0] sh = 8'h00; // bits taken in so far
   int cnt = 0; // bits of this frame
   realtime t_mode = 0.0; // last polarity change; its clock step is no edge
   initial got = 8'h00;
   initial frames = 0;
   always @(cpol) t_mode = $realtime;
   logic [7:0] reply; // byte sent back in this frame
   assign reply = 8'h5A + 8'(frames * 17);
   // reply bit; changes only at a sample edge
   assign miso = reply[lsb_first ? cnt : 7 - cnt];
   always @(sclk) if ($realtime != t_mode && sclk == (cpol == cpha)) begin
      sh = lsb_first ? {mosi, sh[7:1]} : {sh[6:0], mosi};
      cnt = cnt + 1;
      if (cnt == 8) begin
         got = sh;
         cnt = 0;
         frames = frames + 1;
      end
   end
endmodule

// ==== verif/usart_master_spi_transfer_tb_top.sv ====
// testbench for the master spi transfer block
// assumes the slave model answers 5A plus 17 per frame
`timescale 1ns/1ps
module usart_master_spi_transfer_tb_top;
   import umst_pkg::*;
   // ==========================================================
   // signals
   logic mclk, reset_n, tx_enable, rx_enable, lsb, cpha, cpol, wr, rd;
   logic tcc, tca, rc, tc, de, fe, ov, pe, txa, rxa, sdo, oe_n, sdi, sck;
   logic [11:0] baud;
   logic [7:0] wdata, rdata, got, txb;
   int frames, n0, n_errors = 0, cmp_count = 0, cyc = 0;
   umst_spi_master umst_spi_master_i (.mclk(mclk), .reset_n(reset_n),
      .tx_enable(tx_enable), .rx_enable(rx_enable), .data_order_lsb(lsb),
      .clock_phase(cpha), .clock_polarity(cpol), .baud_div(baud),
      .data_write(wr), .data_wdata(wdata), .data_read(rd),
      .data_rdata(rdata), .tx_complete_clear(tcc), .tx_complete_ack(tca),
      .receive_complete_flag(rc), .transmit_complete_flag(tc),
      .data_empty_flag(de), .frame_error_flag(fe), .overrun_flag(ov),
      .parity_error_flag(pe), .tx_active(txa), .rx_active(rxa),
      .serial_output_pin(sdo), .serial_output_pin_oe_n(oe_n),
      .serial_input_pin(sdi), .transfer_clock_pin(sck));
   umst_slave_model umst_slave_model_i (.sclk(sck), .mosi(sdo),
      .cpol(cpol), .cpha(cpha), .lsb_first(lsb), .miso(sdi), .got(got),
      .frames(frames));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // cut a hang short
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end
   // ==========================================================
   // tasks
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      cmp_count++;
      if (a !== e) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, a, e);
      end
   endtask
   task automatic wait_hi(ref logic s);
      int k = 0;
      while (s !== 1'b1 && k < 600) begin
         tick(1);
         k++;
      end
      // a flag that never came is a failure, not a pass-through
      if (s !== 1'b1) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, s, 1'b1);
      end
   endtask
   task automatic send(input logic [7:0] b);
      wait_hi(de);
      wdata = b;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
   endtask
   // read the head, then pop it
   task automatic take(input int f);
      wait_hi(rc);
      tick(2);
      chk(rdata, 8'h5A + 8'(f * 17));
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
   endtask
   task automatic clear_tc;
      tcc = 1'b1;
      tick(1);
      tcc = 1'b0;
      tick(1);
      chk({7'h00, tc}, 8'h00);
   endtask
   task automatic conclude;
      if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ==========================================================
   // sequence
   initial begin
      {reset_n, tx_enable, rx_enable, lsb, cpha, cpol, wr, rd} = 8'h00;
      {tcc, tca, wdata} = 10'h000;
      baud = 12'h003;
      tick(12);
      reset_n = 1'b1;
      chk({de, tc, rc, fe, ov, pe, oe_n, sdo}, 8'h83);
      send(8'h11);
      tick(100);
      chk(8'(frames), 8'h00);
      tx_enable = 1'b1;
      rx_enable = 1'b1;
      tick(1);
      chk({5'h00, oe_n, rxa, txa}, 8'h03);
      for (int m = 0; m < 4; m++) begin
         {cpol, cpha} = 2'(m);
         lsb = m[0];
         txb = 8'hB1 + 8'(m * 29);
         n0 = frames;
         tick(2);
         send(txb);
         wait_hi(tc);
         chk(got, txb);
         take(n0);
         clear_tc();
      end
      n0 = frames;
      send(8'h01);
      send(8'h02);
      send(8'h03);
      wait_hi(tc);
      chk(got, 8'h03);
      take(n0);
      take(n0 + 1);
      chk({7'h00, rc}, 8'h00);
      tca = 1'b1;
      tick(1);
      tca = 1'b0;
      tick(1);
      chk({7'h00, tc}, 8'h00);
      rx_enable = 1'b0;
      send(8'h5C);
      wait_hi(tc);
      chk({got, rc, rxa}, {8'h5C, 2'b00});
      clear_tc();
      rx_enable = 1'b1;
      send(8'h66);
      // let the byte reach the buffer, then flush it
      wait_hi(rc);
      chk({7'h00, rc}, 8'h01);
      rx_enable = 1'b0;
      tick(2);
      chk({7'h00, rc}, 8'h00);
      clear_tc();
      send(8'h99);
      tx_enable = 1'b0;
      tick(4);
      chk({7'h00, txa}, 8'h01);
      wait_hi(tc);
      tick(2);
      chk({got, txa, oe_n}, {8'h99, 2'b01});
      conclude();
   end
endmodule
bind umst_spi_master umst_spi_master_sva umst_spi_master_sva_i (
   .mclk(mclk), .reset_n(reset_n), .rx_enable(rx_enable),
   .clock_polarity(clock_polarity), .data_write(data_write),
   .receive_complete_flag(receive_complete_flag),
   .transmit_complete_flag(transmit_complete_flag),
   .data_empty_flag(data_empty_flag), .frame_error_flag(frame_error_flag),
   .overrun_flag(overrun_flag), .parity_error_flag(parity_error_flag),
   .tx_active(tx_active), .rx_active(rx_active),
   .serial_output_pin(serial_output_pin),
   .serial_output_pin_oe_n(serial_output_pin_oe_n),
   .transfer_clock_pin(transfer_clock_pin));
